// ===== isbsc_top.sv
module isbsc_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // clock sources and divider control
   input wire logic bus_osc_in_i,
   input wire logic doubled_cpu_clock_i,
   input wire logic bus_osc_sel_i,
   input wire logic [isbsc_pkg::DIV_SEL_W-1:0] clock_divider_register_i,
   output logic sysclk_o,
   // ownership
   input wire logic hold_ack_i,
   input wire logic master_n_i,
   // bus controller strobe requests, active high
   input wire logic bc_bale_i,
   input wire logic bc_ior_i,
   input wire logic bc_iow_i,
   input wire logic bc_memr_i,
   input wire logic bc_memw_i,
   // dma strobe requests, active high
   input wire logic dma_ior_i,
   input wire logic dma_iow_i,
   input wire logic dma_memr_i,
   input wire logic dma_memw_i,
   input wire logic dma_tc_i,
   // slot strobes, two-way except bale_o, which is output only
   output logic bale_o,
   input wire logic ior_n_i,
   output logic ior_n_o,
   input wire logic iow_n_i,
   output logic iow_n_o,
   input wire logic memr_n_i,
   output logic memr_n_o,
   input wire logic memw_n_i,
   output logic memw_n_o,
   output logic strobe_oe_o,
   // low-megabyte strobes and terminal count
   input wire logic [isbsc_pkg::ADDR_W-1:0] slot_addr_i,
   output logic smemr_n_o,
   output logic smemw_n_o,
   output logic tc_o,
   // parity
   input wire logic mem_wr_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] wr_data_i,
   input wire logic [15:0] rd_data_i,
   input wire logic [1:0] byte_parity_pins_i,
   output logic [1:0] byte_parity_pins_o,
   output logic [1:0] byte_parity_pins_oe_o,
   output logic parity_err_o,
   output logic [1:0] rom_ws_o,
   // refresh, open drain
   input wire logic refresh_cycle_i,
   input wire logic refresh_n_i,
   output logic refresh_n_o,
   output logic refresh_oe_o,
   output logic [isbsc_pkg::REF_CNT_W-1:0] refresh_addr_o,
   output logic mapper_refresh_sel_o,
   // reset
   input wire logic supply_stable_in_i,
   output logic rstdrv_o,
   // slot cycle control
   input wire logic cyc_start_i,
   input wire isbsc_pkg::isbsc_cyc_t cyc_kind_i,
   input wire logic zero_wait_terminate_n_i,
   output logic cyc_busy_o,
   output logic cyc_done_o
);
   logic osc_prev_ff;
   logic cpu2_prev_ff;
   logic src_tick;
   logic osc_rise;
   logic sys_rise;

   // source edge detection, both inputs taken as synchronous
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         osc_prev_ff <= 1'b0;
         cpu2_prev_ff <= 1'b0;
      end else begin
         osc_prev_ff <= bus_osc_in_i;
         cpu2_prev_ff <= doubled_cpu_clock_i;
      end
   end

   assign osc_rise = bus_osc_in_i & ~osc_prev_ff;
   assign src_tick = bus_osc_sel_i ? osc_rise : (doubled_cpu_clock_i & ~cpu2_prev_ff);

   isbsc_clkdiv u_clkdiv (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .src_tick_i(src_tick),
      .ratio_sel_i(clock_divider_register_i[1:0]),
      .sysclk_o(sysclk_o),
      .rise_o(sys_rise)
   );

   // strobe source and direction
   logic own_bc;
   logic own_dma;
   logic drive;
   logic [4:0] req;
   logic [4:0] strb_ff;
   logic [4:0] nxt_strb;
   logic oe_ff;
   logic nxt_oe;

   // bus controller when no hold, dma when hold and master_n_i high
   assign own_bc = ~hold_ack_i;
   assign own_dma = hold_ack_i & master_n_i;
   assign drive = own_bc | own_dma;

   always_comb begin
      req = 5'h00;
      if (own_bc) begin
         req = {bc_bale_i, bc_ior_i, bc_iow_i, bc_memr_i, bc_memw_i};
      end else if (own_dma) begin
         req = {1'b0, dma_ior_i, dma_iow_i, dma_memr_i, dma_memw_i};
      end
      nxt_strb = strb_ff;
      nxt_oe = drive;
      // takes requests on system clock rise, clears at once when not driving
      if (sys_rise) begin
         nxt_strb = req;
      end
      if (!drive) begin
         nxt_strb = 5'h00;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         strb_ff <= 5'h00;
         oe_ff <= 1'b0;
      end else begin
         strb_ff <= nxt_strb;
         oe_ff <= nxt_oe;
      end
   end

   assign bale_o = strb_ff[4];
   assign ior_n_o = ~strb_ff[3];
   assign iow_n_o = ~strb_ff[2];
   assign memr_n_o = ~strb_ff[1];
   assign memw_n_o = ~strb_ff[0];
   assign strobe_oe_o = oe_ff;

   // low-megabyte strobes and terminal count
   logic low_mb;
   logic rd_active;
   logic wr_active;
   logic smemr_ff;
   logic nxt_smemr;
   logic smemw_ff;
   logic nxt_smemw;
   logic tc_ff;
   logic nxt_tc;

   assign low_mb = ~|slot_addr_i[isbsc_pkg::ADDR_W-1:isbsc_pkg::LOW_MB_BIT];
   // pin level counts, so external master cycles are covered too
   assign rd_active = oe_ff ? strb_ff[1] : ~memr_n_i;
   assign wr_active = oe_ff ? strb_ff[0] : ~memw_n_i;

   always_comb begin
      nxt_smemr = ~refresh_n_i | (rd_active & low_mb);
      nxt_smemw = wr_active & low_mb;
      nxt_tc = dma_tc_i;
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         smemr_ff <= 1'b0;
         smemw_ff <= 1'b0;
         tc_ff <= 1'b0;
      end else begin
         smemr_ff <= nxt_smemr;
         smemw_ff <= nxt_smemw;
         tc_ff <= nxt_tc;
      end
   end

   assign smemr_n_o = ~smemr_ff;
   assign smemw_n_o = ~smemw_ff;
   assign tc_o = tc_ff;

   // parity and ROM wait strap
   logic strap_done_ff;
   logic nxt_strap_done;
   logic [1:0] rom_ws_ff;
   logic [1:0] nxt_rom_ws;
   logic par_wr;
   logic par_chk;

   assign par_wr = mem_wr_i & strap_done_ff;
   assign par_chk = mem_rd_i & strap_done_ff;

   isbsc_parity #(
      .BYTES(2),
      .ODD(1'b1)
   ) u_parity (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .wr_en_i(par_wr),
      .chk_en_i(par_chk),
      .wr_data_i(wr_data_i),
      .rd_data_i(rd_data_i),
      .par_i(byte_parity_pins_i),
      .par_o(byte_parity_pins_o),
      .par_oe_o(byte_parity_pins_oe_o),
      .err_o(parity_err_o)
   );

   always_comb begin
      nxt_strap_done = 1'b1;
      nxt_rom_ws = rom_ws_ff;
      if (!strap_done_ff) begin
         nxt_rom_ws = byte_parity_pins_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         strap_done_ff <= 1'b0;
         rom_ws_ff <= isbsc_pkg::STRAP_DEFAULT;
      end else begin
         strap_done_ff <= nxt_strap_done;
         rom_ws_ff <= nxt_rom_ws;
      end
   end

   assign rom_ws_o = rom_ws_ff;

   // refresh line and counter
   logic ref_oe_ff;
   logic nxt_ref_oe;
   logic ref_prev_ff;
   logic [isbsc_pkg::REF_CNT_W-1:0] ref_cnt_ff;
   logic [isbsc_pkg::REF_CNT_W-1:0] nxt_ref_cnt;
   logic map_sel_ff;

   always_comb begin
      nxt_ref_oe = refresh_cycle_i;
      nxt_ref_cnt = ref_cnt_ff;
      if (ref_prev_ff & ~refresh_n_i) begin
         nxt_ref_cnt = ref_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         ref_oe_ff <= 1'b0;
         ref_prev_ff <= 1'b1;
         ref_cnt_ff <= '0;
         map_sel_ff <= 1'b0;
      end else begin
         ref_oe_ff <= nxt_ref_oe;
         ref_prev_ff <= refresh_n_i;
         ref_cnt_ff <= nxt_ref_cnt;
         map_sel_ff <= ~refresh_n_i;
      end
   end

   assign refresh_n_o = 1'b0;
   assign refresh_oe_o = ref_oe_ff;
   assign refresh_addr_o = ref_cnt_ff;
   assign mapper_refresh_sel_o = map_sel_ff;

   // slot reset
   logic rstdrv_ff;
   logic nxt_rstdrv;

   always_comb begin
      nxt_rstdrv = rstdrv_ff;
      if (osc_rise) begin
         nxt_rstdrv = ~supply_stable_in_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rstdrv_ff <= 1'b1;
      end else begin
         rstdrv_ff <= nxt_rstdrv;
      end
   end

   assign rstdrv_o = rstdrv_ff;

   // slot cycle length
   isbsc_pkg::isbsc_state_t st_ff;
   isbsc_pkg::isbsc_state_t nxt_st;
   logic [3:0] ws_ff;
   logic [3:0] nxt_ws;
   logic cpu_cyc_ff;
   logic nxt_cpu_cyc;
   logic [3:0] ws_load;

   always_comb begin
      unique case (cyc_kind_i)
         isbsc_pkg::CYC_IO8: ws_load = isbsc_pkg::WS_IO8;
         isbsc_pkg::CYC_IO16: ws_load = isbsc_pkg::WS_IO16;
         isbsc_pkg::CYC_ROM: ws_load = {2'h0, rom_ws_ff};
         isbsc_pkg::CYC_DMA: ws_load = isbsc_pkg::WS_DMA;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_ws = ws_ff;
      nxt_cpu_cyc = cpu_cyc_ff;
      unique case (st_ff)
         isbsc_pkg::ST_IDLE: begin
            if (cyc_start_i) begin
               nxt_ws = ws_load;
               nxt_cpu_cyc = cyc_kind_i != isbsc_pkg::CYC_DMA;
               nxt_st = isbsc_pkg::ST_CMD;
            end
         end
         isbsc_pkg::ST_CMD: begin
            if (sys_rise) begin
               nxt_st = isbsc_pkg::ST_WAIT;
            end
         end
         isbsc_pkg::ST_WAIT: begin
            if (sys_rise) begin
               if ((cpu_cyc_ff & ~zero_wait_terminate_n_i) || ws_ff == 4'h0) begin
                  nxt_st = isbsc_pkg::ST_END;
               end else begin
                  nxt_ws = ws_ff - 4'h1;
               end
            end
         end
         isbsc_pkg::ST_END: begin
            nxt_st = isbsc_pkg::ST_IDLE;
         end
         default: begin
            nxt_st = isbsc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         st_ff <= isbsc_pkg::ST_IDLE;
         ws_ff <= 4'h0;
         cpu_cyc_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         ws_ff <= nxt_ws;
         cpu_cyc_ff <= nxt_cpu_cyc;
      end
   end

   assign cyc_busy_o = st_ff != isbsc_pkg::ST_IDLE;
   assign cyc_done_o = st_ff == isbsc_pkg::ST_END;
endmodule : isbsc_top

// ===== isbsc_pkg.sv
// Overview of operation
// - memory strobes input only under external master
// - strobes from bus controller or DMA
// - one parity bit generated per written byte
// - parity pins input and checked on reads
// - parity pins strapped at reset set ROM waits
// - pull refresh line low on refresh start
// - refresh line sensed for external requests
// - each refresh steps address counter, selects mapper
// - slot reset from supply good, oscillator timed
// - low-memory read strobe on refresh, reads below 1MB
// - low-memory write strobe on writes below 1MB
// - system clock divides chosen source by 2/4/6/8
// - bus strobes change on system clock, clear at once when not driving
// - terminal count driven onto the bus
// - zero-wait input ends CPU cycle early
// - default waits 4, 1, 3 ROM, DMA 1
package isbsc_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   // default wait states per cycle kind
   localparam logic [3:0] WS_IO8 = 4'h4;
   localparam logic [3:0] WS_IO16 = 4'h1;
   localparam logic [3:0] WS_ROM = 4'h3;
   localparam logic [3:0] WS_DMA = 4'h1;
   // strap value read from pulled-up parity pins
   localparam logic [1:0] STRAP_DEFAULT = 2'h3;
   // address bits that must be zero below the first megabyte
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned LOW_MB_BIT = 20;
   localparam int unsigned REF_CNT_W = 8;
   localparam int unsigned DIV_SEL_W = 4;

   typedef enum logic [1:0] {
      CYC_IO8 = 2'h0,
      CYC_IO16 = 2'h1,
      CYC_ROM = 2'h2,
      CYC_DMA = 2'h3
   } isbsc_cyc_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_CMD = 4'h2,
      ST_WAIT = 4'h4,
      ST_END = 4'h8
   } isbsc_state_t;
endpackage : isbsc_pkg

// ===== isbsc_clkdiv.sv
module isbsc_clkdiv (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // source edges and ratio
   input wire logic src_tick_i,
   input wire logic [1:0] ratio_sel_i,
   // divided clock
   output logic sysclk_o,
   output logic rise_o
);
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic sysclk_ff;
   logic nxt_sysclk;
   logic rise_ff;
   logic nxt_rise;

   // half period of sel+1 source edges
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_sysclk = sysclk_ff;
      nxt_rise = 1'b0;
      if (src_tick_i) begin
         if (cnt_ff >= ratio_sel_i) begin
            nxt_cnt = 2'h0;
            nxt_sysclk = ~sysclk_ff;
            nxt_rise = ~sysclk_ff;
         end else begin
            nxt_cnt = cnt_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         cnt_ff <= 2'h0;
         sysclk_ff <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         sysclk_ff <= nxt_sysclk;
         rise_ff <= nxt_rise;
      end
   end

   assign sysclk_o = sysclk_ff;
   assign rise_o = rise_ff;
endmodule : isbsc_clkdiv

// ===== isbsc_parity.sv
module isbsc_parity #(
   parameter int unsigned BYTES = 2,
   parameter bit ODD = 1'b1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // memory side
   input wire logic wr_en_i,
   input wire logic chk_en_i,
   input wire logic [8*BYTES-1:0] wr_data_i,
   input wire logic [8*BYTES-1:0] rd_data_i,
   // parity pins
   input wire logic [BYTES-1:0] par_i,
   output logic [BYTES-1:0] par_o,
   output logic [BYTES-1:0] par_oe_o,
   // check result
   output logic err_o
);
   logic [BYTES-1:0] gen_bit;
   logic [BYTES-1:0] bad_bit;
   logic [BYTES-1:0] par_ff;
   logic [BYTES-1:0] nxt_par;
   logic [BYTES-1:0] oe_ff;
   logic [BYTES-1:0] nxt_oe;
   logic err_ff;
   logic nxt_err;

   for (genvar b = 0; b < BYTES; b++) begin : g_byte
      assign gen_bit[b] = (^wr_data_i[8*b+7:8*b]) ^ ODD;
      assign bad_bit[b] = (^rd_data_i[8*b+7:8*b]) ^ par_i[b] ^ ODD;
   end

   always_comb begin
      nxt_par = par_ff;
      nxt_oe = {BYTES{1'b0}};
      nxt_err = 1'b0;
      if (wr_en_i) begin
         nxt_par = gen_bit;
         nxt_oe = {BYTES{1'b1}};
      end else if (chk_en_i) begin
         nxt_err = |bad_bit;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         par_ff <= {BYTES{1'b0}};
         oe_ff <= {BYTES{1'b0}};
         err_ff <= 1'b0;
      end else begin
         par_ff <= nxt_par;
         oe_ff <= nxt_oe;
         err_ff <= nxt_err;
      end
   end

   assign par_o = par_ff;
   assign par_oe_o = oe_ff;
   assign err_o = err_ff;
endmodule : isbsc_parity

// ===== isbsc_slot_card.sv
module isbsc_slot_card (
   // bench controls
   input wire logic [15:0] rd_data_i,
   input wire logic rd_en_i,
   input wire logic [1:0] bad_par_i,
   input wire logic master_en_i,
   input wire logic ext_refresh_i,
   input wire logic fast_i,
   input wire logic busy_i,
   // slot pins
   output logic [1:0] par_o,
   output logic par_oe_o,
   output logic memr_n_o,
   output logic mem_oe_o,
   output logic refresh_pull_o,
   output logic zws_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   assign par_oe_o = rd_en_i;
   assign par_o = {~^rd_data_i[15:8], ~^rd_data_i[7:0]} ^ bad_par_i;
   assign mem_oe_o = master_en_i;
   assign memr_n_o = 1'b0;
   assign refresh_pull_o = ext_refresh_i;
   assign zws_n_o = ~(fast_i & busy_i);
endmodule : isbsc_slot_card

// ===== isbsc_top_chk.sv
module isbsc_top_chk (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // watched ports
   input wire logic hold_ack_i,
   input wire logic master_n_i,
   input wire logic strobe_oe_o,
   input wire logic memr_n_o,
   input wire logic sysclk_o,
   input wire logic dma_tc_i,
   input wire logic tc_o,
   input wire logic mem_wr_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] wr_data_i,
   input wire logic [15:0] rd_data_i,
   input wire logic [1:0] byte_parity_pins_i,
   input wire logic [1:0] byte_parity_pins_o,
   input wire logic [1:0] byte_parity_pins_oe_o,
   input wire logic parity_err_o,
   input wire logic refresh_cycle_i,
   input wire logic refresh_n_i,
   input wire logic refresh_oe_o,
   input wire logic [isbsc_pkg::REF_CNT_W-1:0] refresh_addr_o,
   input wire logic [isbsc_pkg::ADDR_W-1:0] slot_addr_i,
   input wire logic smemw_n_o,
   input wire logic cyc_start_i,
   input wire logic cyc_busy_o,
   input wire logic cyc_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wpar;
   logic rbad;
   logic low_mb;
   assign wpar = {~^wr_data_i[15:8], ~^wr_data_i[7:0]};
   assign rbad = |(byte_parity_pins_i ^ {~^rd_data_i[15:8], ~^rd_data_i[7:0]});
   assign low_mb = slot_addr_i[23:20] == 4'h0;
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   strobe_release_a: assert property (hold_ack_i && !master_n_i |=> !strobe_oe_o)
      else $error("strobes driven under external master");
   tc_follow_a: assert property (1'b1 |=> tc_o == $past(dma_tc_i))
      else $error("terminal count not passed to bus");
   par_gen_a: assert property (mem_wr_i |=> byte_parity_pins_oe_o == 2'h3
      && byte_parity_pins_o == $past(wpar)) else $error("write parity wrong");
   par_chk_a: assert property (mem_rd_i && !mem_wr_i |=> byte_parity_pins_oe_o == 2'h0
      && parity_err_o == $past(rbad)) else $error("read parity check wrong");
   ref_pull_a: assert property (refresh_cycle_i |=> refresh_oe_o)
      else $error("refresh line not pulled");
   ref_count_a: assert property ($fell(refresh_n_i) |-> ##2
      refresh_addr_o == 8'($past(refresh_addr_o, 2) + 8'h01)) else $error("refresh count");
   smemw_low_a: assert property (!smemw_n_o |-> $past(low_mb))
      else $error("low write strobe above first megabyte");
   strobe_sync_a: assert property ($fell(memr_n_o) |-> $past(sysclk_o)
      && !$past(sysclk_o, 2)) else $error("read strobe off system clock");
   cyc_done_a: assert property (cyc_start_i && !cyc_busy_o |-> ##[2:600] cyc_done_o)
      else $error("slot cycle never ended");
endmodule : isbsc_top_chk
bind isbsc_top isbsc_top_chk i_chk (.mclk_i, .reset_n_i, .hold_ack_i, .master_n_i,
   .strobe_oe_o, .memr_n_o, .sysclk_o, .dma_tc_i, .tc_o, .mem_wr_i, .mem_rd_i, .wr_data_i,
   .rd_data_i, .byte_parity_pins_i, .byte_parity_pins_o, .byte_parity_pins_oe_o,
   .parity_err_o, .refresh_cycle_i, .refresh_n_i, .refresh_oe_o, .refresh_addr_o,
   .slot_addr_i, .smemw_n_o, .cyc_start_i, .cyc_busy_o, .cyc_done_o);

// ===== tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIM = 400;
   logic mclk_i = 1'b0, reset_n_i = 1'b0, osc = 1'b0, tclk = 1'b0, osc_sel = 1'b1;
   logic hold = 1'b0, mst_n = 1'b1, mwr = 1'b0, mrd = 1'b0, rcyc = 1'b0, supply = 1'b0;
   logic start = 1'b0, mst_en = 1'b0, ext_ref = 1'b0, fast = 1'b0;
   logic [3:0] div = 4'h0;
   logic [4:0] bc = 5'h00, dma = 5'h00;
   logic [23:0] addr = 24'h000000;
   logic [15:0] wd = 16'h0000, rd = 16'h0000;
   logic [1:0] kind = 2'h0, bad = 2'h0, par_pull = 2'h2;
   logic sysclk_o, ior_n, iow_n, memr_n_o, memw_n_o, strobe_oe_o, smemr_n_o, smemw_n_o;
   logic tc_o, perr, bale, ref_o, ref_oe, map_sel, rstdrv_o, busy, done;
   logic [1:0] par_o, par_oe, rom_ws, c_par;
   logic [7:0] ref_addr;
   logic c_par_oe, c_memr_n, c_mem_oe, c_ref, zws_n;
   wire [1:0] par_pin = (par_oe & par_o) | (~par_oe & (c_par_oe ? c_par : par_pull));
   wire memr_pin = strobe_oe_o ? memr_n_o : (c_mem_oe ? c_memr_n : 1'b1);
   wire memw_pin = strobe_oe_o ? memw_n_o : 1'b1;
   wire ior_pin = strobe_oe_o ? ior_n : 1'b1;
   wire iow_pin = strobe_oe_o ? iow_n : 1'b1;
   wire ref_pin = ~((ref_oe & ~ref_o) | c_ref);
   int err_total = 0, n_tests = 0;

   isbsc_top i_dut (.mclk_i, .reset_n_i, .bus_osc_in_i(osc), .doubled_cpu_clock_i(tclk),
      .bus_osc_sel_i(osc_sel), .clock_divider_register_i(div), .sysclk_o, .hold_ack_i(hold),
      .master_n_i(mst_n), .bc_bale_i(bc[4]), .bc_ior_i(bc[3]), .bc_iow_i(bc[2]),
      .bc_memr_i(bc[1]), .bc_memw_i(bc[0]), .dma_ior_i(dma[4]), .dma_iow_i(dma[3]),
      .dma_memr_i(dma[2]), .dma_memw_i(dma[1]), .dma_tc_i(dma[0]), .bale_o(bale),
      .ior_n_i(ior_pin), .ior_n_o(ior_n), .iow_n_i(iow_pin), .iow_n_o(iow_n),
      .memr_n_i(memr_pin), .memr_n_o, .memw_n_i(memw_pin), .memw_n_o, .strobe_oe_o,
      .slot_addr_i(addr), .smemr_n_o, .smemw_n_o, .tc_o, .mem_wr_i(mwr), .mem_rd_i(mrd),
      .wr_data_i(wd), .rd_data_i(rd), .byte_parity_pins_i(par_pin), .byte_parity_pins_o(par_o),
      .byte_parity_pins_oe_o(par_oe), .parity_err_o(perr), .rom_ws_o(rom_ws),
      .refresh_cycle_i(rcyc), .refresh_n_i(ref_pin), .refresh_n_o(ref_o),
      .refresh_oe_o(ref_oe), .refresh_addr_o(ref_addr), .mapper_refresh_sel_o(map_sel),
      .supply_stable_in_i(supply), .rstdrv_o, .cyc_start_i(start),
      .cyc_kind_i(isbsc_pkg::isbsc_cyc_t'(kind)), .zero_wait_terminate_n_i(zws_n),
      .cyc_busy_o(busy), .cyc_done_o(done));

   isbsc_slot_card i_card (.rd_data_i(rd), .rd_en_i(mrd), .bad_par_i(bad),
      .master_en_i(mst_en), .ext_refresh_i(ext_ref), .fast_i(fast), .busy_i(busy),
      .par_o(c_par), .par_oe_o(c_par_oe), .memr_n_o(c_memr_n), .mem_oe_o(c_mem_oe),
      .refresh_pull_o(c_ref), .zws_n_o(zws_n));

   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   // oscillator period 2 clocks, doubled cpu clock period 4
   always @(posedge mclk_i) begin
      #2;
      osc <= ~osc;
      if (osc) tclk <= ~tclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic to(input int k);
      if (k >= LIM) begin
         err_total++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, k, LIM);
         end_sim();
      end
   endtask : to

   // waits for the next low-to-high change of the system clock
   task automatic rise(inout int c);
      int k;
      for (k = 0; k < LIM && sysclk_o !== 1'b0; k++) begin cyc(1); c++; end
      for (; k < LIM && sysclk_o !== 1'b1; k++) begin cyc(1); c++; end
      to(k);
   endtask : rise

   function automatic int wsx(input int k);
      case (k)
         0: return int'(isbsc_pkg::WS_IO8);
         1: return int'(isbsc_pkg::WS_IO16);
         2: return 2;
         default: return int'(isbsc_pkg::WS_DMA);
      endcase
   endfunction : wsx

   initial begin
      int i, k, c, f;
      int s[8];
      logic p;
      logic [15:0] d;
      logic [7:0] r0;
      void'($urandom(32'hd153));
      repeat (12) @(posedge mclk_i);
      #2;
      chk(rstdrv_o, 1'b1);
      chk({memr_n_o, memw_n_o, smemr_n_o}, 3'h7);
      chk(strobe_oe_o, 1'b0);
      reset_n_i = 1'b1;
      cyc(2);
      chk(rom_ws, 2'h2);
      par_pull = 2'h3;
      supply = 1'b1;
      cyc(6);
      chk(rstdrv_o, 1'b0);
      $display("reset test done");
      for (f = 0; f < 2; f++) begin
         for (i = 0; i < 4; i++) begin
            osc_sel = f[0];
            div = 4'($urandom_range(3, 0) * 4) | 4'(i);
            c = 0;
            rise(c);
            rise(c);
            c = 0;
            rise(c);
            chk(c, 2 * (i + 1) * (f ? 2 : 4));
         end
      end
      $display("divider test done");
      addr = 24'h0F0000;
      bc = 5'h19;
      for (k = 0; k < LIM && memw_n_o !== 1'b0; k++) cyc(1);
      to(k);
      chk(strobe_oe_o, 1'b1);
      chk({bale, ior_n, iow_n}, 3'h5);
      cyc(1);
      chk(smemw_n_o, 1'b0);
      addr = 24'hF00000;
      cyc(2);
      chk(smemw_n_o, 1'b1);
      hold = 1'b1;
      dma = 5'h0C;
      for (k = 0; k < LIM && memr_n_o !== 1'b0; k++) cyc(1);
      to(k);
      chk({bale, ior_n, iow_n, memw_n_o}, 4'h5);
      mst_n = 1'b0;
      mst_en = 1'b1;
      addr = 24'h0F0000;
      cyc(2);
      chk(strobe_oe_o, 1'b0);
      chk(smemr_n_o, 1'b0);
      addr = 24'h100000;
      cyc(2);
      chk(smemr_n_o, 1'b1);
      mst_en = 1'b0;
      mst_n = 1'b1;
      hold = 1'b0;
      dma = 5'h00;
      bc = 5'h00;
      $display("strobe test done");
      for (i = 0; i < 24; i++) begin
         d = 16'($urandom);
         wd = d;
         mwr = 1'b1;
         dma[0] = 1'($urandom);
         cyc(1);
         chk({par_oe, par_o}, {2'h3, ~^d[15:8], ~^d[7:0]});
         chk(tc_o, dma[0]);
         mwr = 1'b0;
         // write parity stays driven one cycle, so idle before the read
         cyc(1);
         chk(par_oe, 2'h0);
         rd = d;
         bad = (i < 4) ? 2'(i) : 2'($urandom);
         mrd = 1'b1;
         cyc(1);
         mrd = 1'b0;
         chk({par_oe, perr}, {2'h0, |bad});
      end
      bad = 2'h0;
      $display("parity test done");
      r0 = ref_addr;
      addr = 24'h000000;
      rcyc = 1'b1;
      cyc(1);
      chk(ref_oe, 1'b1);
      rcyc = 1'b0;
      cyc(1);
      chk({map_sel, smemr_n_o}, 2'h2);
      cyc(3);
      chk(ref_addr, r0 + 8'h01);
      ext_ref = 1'b1;
      cyc(1);
      ext_ref = 1'b0;
      cyc(4);
      chk(ref_addr, r0 + 8'h02);
      $display("refresh test done");
      osc_sel = 1'b1;
      div = 4'h1;
      for (f = 0; f < 2; f++) begin
         for (i = 0; i < 4; i++) begin
            fast = f[0];
            kind = 2'(i);
            rise(c);
            start = 1'b1;
            p = sysclk_o;
            cyc(1);
            start = 1'b0;
            c = 0;
            for (k = 0; k < LIM && done !== 1'b1; k++) begin
               if (sysclk_o === 1'b1 && p === 1'b0) c++;
               p = sysclk_o;
               cyc(1);
            end
            to(k);
            s[f * 4 + i] = c;
            cyc(1);
         end
      end
      fast = 1'b0;
      for (i = 0; i < 4; i++) begin
         chk(s[i], s[1] + wsx(i) - 1);
         chk(s[4 + i], (i == 3) ? s[3] : s[1] - 1);
      end
      $display("slot cycle test done");
      end_sim();
   end
endmodule : tb_top
